/* File: tb/mdmst_dev_model.sv */
/* behavioural managed device: one slave with 32 registers on the wire.
   assumes the bus clock runs only within frames and the wire is pulled up. */
`timescale 1ns/1ps
module mdmst_dev_model
  import mdmst_pkg::*;
(
  // bus
  input  logic       i_mgmt_clock,
  input  logic       i_arst_n,
  input  logic       i_mgmt_data,
  input  logic [4:0] i_slave_addr,
  // drive toward the wire
  output logic       o_data,
  output logic       o_oe
);
  logic [15:0] regs [32];
  logic [15:0] shift_reg;
  logic [6:0]  bit_reg;
  logic [4:0]  ra_reg;
  logic [1:0]  op_reg;
  logic        sel_reg;
  // the device's own master is kept off: its divide stays at zero, so it
  // starts no frame and leaves its clock output idle
  localparam logic [5:0] DEV_DIVIDE  = 6'h00;
  localparam logic       DEV_MGMT_EN = 1'b1;
  if (DEV_DIVIDE != 6'h00) begin : g_dev_master_on
    $error("mdmst_dev_model: the device master must stay disabled");
  end
  always_ff @(posedge i_mgmt_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_reg <= '0;
      sel_reg <= 1'b0;
    end else begin
      shift_reg <= {shift_reg[14:0], i_mgmt_data};
      bit_reg   <= (bit_reg == 7'd63) ? 7'd0 : bit_reg + 7'd1;
      if (bit_reg == 7'd45) begin
        sel_reg <= DEV_MGMT_EN && (shift_reg[8:4] == i_slave_addr || shift_reg[8:4] == 5'h00);
        op_reg  <= shift_reg[10:9];
        ra_reg  <= {shift_reg[3:0], i_mgmt_data};
      end
      if (bit_reg == 7'd63 && sel_reg && op_reg == MDMST_OP_WRITE) begin
        regs[ra_reg] <= {shift_reg[14:0], i_mgmt_data};
      end
    end
  end
  // changes on the falling clock so the value is settled long before the rise
  always_ff @(negedge i_mgmt_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_oe   <= 1'b0;
      o_data <= 1'b1;
    end else begin
      o_oe   <= sel_reg && op_reg == MDMST_OP_READ && bit_reg >= 7'd47;
      o_data <= (bit_reg == 7'd47) ? 1'b0 : regs[ra_reg][4'(7'd63 - bit_reg)];
    end
  end
endmodule : mdmst_dev_model

/* File: tb/mdmst_master_checker.sv */
/* assertions on the master's order port and bus pins.
   assumes a bind into the master with its divide handed on. */
`timescale 1ns/1ps
module mdmst_master_checker
  import mdmst_pkg::*;
#(parameter logic [5:0] DIVIDE = MDMST_DIV_DEFAULT) (
  // order port
  input logic       i_core_clk,
  input logic       i_arst_n,
  input logic       i_cmd_valid,
  input mdmst_cmd_t i_cmd,
  input logic       o_cmd_ready,
  input logic       o_rsp_valid,
  input mdmst_rsp_t o_rsp,
  input logic       o_busy,
  // pins
  input logic       o_mgmt_clock,
  input logic       o_mgmt_data,
  input logic       o_mgmt_data_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [6:0] rise_reg;
  logic [6:0] high_reg;
  logic       wr_reg;
  // rises counted per frame so pin checks know which field is on the wire
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_reg <= '0;
      high_reg <= '0;
      wr_reg   <= 1'b0;
    end else begin
      high_reg <= o_mgmt_clock ? high_reg + 7'd1 : 7'd0;
      if (i_cmd_valid && o_cmd_ready) begin
        rise_reg <= '0;
        wr_reg   <= i_cmd.is_write;
      end else if ($rose(o_mgmt_clock)) begin
        rise_reg <= rise_reg + 7'd1;
      end
    end
  end
  sequence s_take; i_cmd_valid && o_cmd_ready; endsequence
  sequence s_run; o_busy && !o_cmd_ready; endsequence
  property p_take; s_take |=> s_run; endproperty
  a_take: assert property (p_take) else $error("order not taken");
  property p_ready; o_cmd_ready != o_busy; endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_pulse; o_rsp_valid |=> !o_rsp_valid && o_cmd_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer not one cycle");
  property p_len; o_rsp_valid |-> rise_reg == 7'd64 && o_rsp.was_write == wr_reg; endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_high; $fell(o_mgmt_clock) |-> high_reg == {1'b0, DIVIDE} + 7'd1; endproperty
  a_high: assert property (p_high) else $error("clock high time wrong");
  property p_idle; !o_busy |-> !o_mgmt_clock && o_mgmt_data && o_mgmt_data_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle pins wrong");
  property p_rd_oe; $rose(o_mgmt_clock) && !wr_reg |-> o_mgmt_data_oe == (rise_reg < 7'd46); endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read release wrong");
  property p_steady; $changed(o_mgmt_data) || $changed(o_mgmt_data_oe) |-> !o_mgmt_clock; endproperty
  a_steady: assert property (p_steady) else $error("data moved while clock high");
endmodule : mdmst_master_checker

bind mdmst_master mdmst_master_checker #(.DIVIDE(DIVIDE)) u_chk (
  .i_core_clk, .i_arst_n, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_rsp_valid, .o_rsp, .o_busy,
  .o_mgmt_clock, .o_mgmt_data, .o_mgmt_data_oe
);

/* File: tb/test_mdio_management_master.sv */
/* bench for the management master with a device model on the wire.
   assumes the design's default divide and a pulled-up data wire. */
`timescale 1ns/1ps
module test_mdio_management_master;
  import mdmst_pkg::*;
  typedef struct packed {mdmst_rsp_t rsp; logic [63:0] frm;} mdmst_note_t;
  localparam logic [4:0] SLAVE = 5'h0b;
  logic i_core_clk, i_arst_n, i_cmd_valid, o_cmd_ready, o_rsp_valid, o_busy;
  logic o_mgmt_clock, o_mgmt_data, o_mgmt_data_oe, dev_data, dev_oe, mdio;
  mdmst_cmd_t  i_cmd;
  mdmst_rsp_t  o_rsp;
  logic [63:0] frm;
  mdmst_note_t notes[$];
  mdmst_note_t n;
  int          err_total, samples_checked;
  assign mdio = o_mgmt_data_oe ? o_mgmt_data : dev_oe ? dev_data : 1'b1;
  mdmst_master i_dut (.i_core_clk, .i_arst_n, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_rsp_valid, .o_rsp,
    .o_busy, .o_mgmt_clock, .o_mgmt_data, .o_mgmt_data_oe, .i_mgmt_data(mdio));
  mdmst_dev_model i_dev (.i_mgmt_clock(o_mgmt_clock), .i_arst_n, .i_mgmt_data(mdio),
    .i_slave_addr(SLAVE), .o_data(dev_data), .o_oe(dev_oe));
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // leaves the order valid; the caller drops it or chains the next order
  task automatic order(input logic w, input logic [4:0] pa, ra, input logic [15:0] d, input logic [16:0] ex);
    notes.push_back({ex, w, MDMST_PREAMBLE, MDMST_START, w ? MDMST_OP_WRITE : MDMST_OP_READ, pa, ra,
      MDMST_TA_WRITE, d});
    i_cmd_valid <= 1'b1;
    i_cmd <= {w, pa, ra, d};
    do @(posedge i_core_clk); while (o_cmd_ready !== 1'b1);
  endtask : order
  task automatic pair(input logic [4:0] pw, pr, ra);
    logic [15:0] d;
    d = 16'($urandom);
    order(1'b1, pw, ra, d, '0);
    order(1'b0, pr, ra, ~d, {d, 1'b0});
  endtask : pair
  always @(posedge o_mgmt_clock) frm <= {frm[62:0], mdio};
  always @(posedge i_core_clk) begin
    if (i_arst_n === 1'b1 && o_rsp_valid === 1'b1) begin
      if (notes.size() == 0) check("spare answer", 1, 0);
      else begin
        n = notes.pop_front();
        if (n.rsp.was_write) check("write answer", o_rsp, n.rsp);
        else check("read answer", o_rsp, n.rsp);
        check("header", frm[63:18], n.frm[63:18]);
        if (n.rsp.was_write) check("write tail", frm[17:0], n.frm[17:0]);
      end
    end
  end
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (50000) @(posedge i_core_clk);
    err_total++;
    end_sim;
  end
  initial begin
    i_arst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(94989));
    repeat (16) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    // back to back, alternating broadcast and own address, both register halves
    for (int i = 0; i < 4; i++) pair(i[0] ? 5'h00 : SLAVE, i[0] ? SLAVE : 5'h00, 5'(i * 8 + 7));
    order(1'b0, 5'h1f, 5'h02, 16'h0, {MDMST_READ_FILL, 1'b1});
    i_cmd_valid <= 1'b0;
    while (notes.size() != 0) @(posedge i_core_clk);
    order(1'b1, SLAVE, 5'h01, 16'h0, '0);
    i_cmd_valid <= 1'b0;
    repeat (700) @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    notes.delete();
    repeat (2) @(posedge i_core_clk);
    check("reset", {o_rsp, o_busy, o_cmd_ready, o_mgmt_clock, o_mgmt_data, o_mgmt_data_oe, o_rsp_valid},
      {18'h0, 6'b010110});
    i_arst_n <= 1'b1;
    pair(SLAVE, SLAVE, 5'h00);
    i_cmd_valid <= 1'b0;
    while (notes.size() != 0) @(posedge i_core_clk);
    end_sim;
  end
endmodule : test_mdio_management_master

/* File: verilog/mdmst_clkdiv.sv */
/*
  management clock divider: makes the bus clock and one-cycle strobes that
  mark the last core cycle before it rises or falls.
  assumes i_run is a same-domain level; the clock is held low while it is low.
*/
`timescale 1ns/1ps

module mdmst_clkdiv
  import mdmst_pkg::*;
#(
  parameter logic [5:0] DIVIDE = MDMST_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  // control
  input  wire logic i_run,
  // bus clock and edge strobes
  output logic      o_mdc,
  output logic      o_rise,
  output logic      o_fall
);

  if (DIVIDE == 6'h00) begin : g_bad_divide
    $error("mdmst_clkdiv: a divide of zero is not allowed");
  end

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic       mdc_reg;
  logic       mdc_next;
  logic       term;

  ////////////////////////////////////////////////////////////////////////////
  assign term = i_run && (cnt_reg == DIVIDE);

  always_comb begin
    cnt_next = cnt_reg;
    mdc_next = mdc_reg;
    if (!i_run) begin
      cnt_next = 6'h00;
      mdc_next = MDMST_IDLE_CLK;
    end else if (term) begin
      cnt_next = 6'h00;
      mdc_next = !mdc_reg;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 6'h00;
      mdc_reg <= MDMST_IDLE_CLK;
    end else begin
      cnt_reg <= cnt_next;
      mdc_reg <= mdc_next;
    end
  end

  assign o_mdc  = mdc_reg;
  assign o_rise = term && !mdc_reg;
  assign o_fall = term && mdc_reg;

endmodule : mdmst_clkdiv

/* File: verilog/mdmst_master.sv */
/*
  outside management-serial master: takes read and write orders at a plain
  user port and runs whole frames on the device's management clock and data
  pins, supplying the clock itself.
  assumes the data wire is pulled up and joined from o_mgmt_data,
  o_mgmt_data_oe and the device's own drivers by the surrounding logic.
*/
`timescale 1ns/1ps

module mdmst_master
  import mdmst_pkg::*;
#(
  parameter logic [5:0] DIVIDE = MDMST_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // order port
  input  wire logic        i_cmd_valid,
  input  wire mdmst_cmd_t  i_cmd,
  output logic             o_cmd_ready,
  // answer port
  output logic             o_rsp_valid,
  output mdmst_rsp_t       o_rsp,
  output logic             o_busy,
  // management pins toward the device
  output logic             o_mgmt_clock,
  output logic             o_mgmt_data,
  output logic             o_mgmt_data_oe,
  input  wire logic        i_mgmt_data
);

  // a faster divide would break the bus clock ceiling
  if (MDMST_CORE_CLK_KHZ > 2 * (int'(DIVIDE) + 1) * MDMST_MDC_MAX_KHZ) begin : g_too_fast
    $error("mdmst_master: DIVIDE gives a bus clock above the ceiling");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  mdmst_state_t  state_reg;
  mdmst_state_t  state_next;
  logic [63:0]   shift_reg;
  logic [63:0]   shift_next;
  logic [5:0]    bit_reg;
  logic [5:0]    bit_next;
  logic          write_reg;
  logic          write_next;
  logic          dout_reg;
  logic          dout_next;
  logic          oe_reg;
  logic          oe_next;
  logic [15:0]   rdata_reg;
  logic [15:0]   rdata_next;
  logic          nores_reg;
  logic          nores_next;
  logic          din_meta_reg;
  logic          din_sync_reg;
  logic          run;
  logic          mdc;
  logic          mdc_rise;
  logic          mdc_fall;
  logic [1:0]    op_field;
  logic [1:0]    ta_field;
  logic [15:0]   data_field;

  ////////////////////////////////////////////////////////////////////////////
  // bus clock, made here from the core clock
  assign run = (state_reg == MDMST_SHIFT);

  mdmst_clkdiv #(
    .DIVIDE (DIVIDE)
  ) u_clkdiv (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (run),
    .o_mdc      (mdc),
    .o_rise     (mdc_rise),
    .o_fall     (mdc_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // the wire level comes from outside, so it is synchronised first
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      din_meta_reg <= MDMST_IDLE_DATA;
      din_sync_reg <= MDMST_IDLE_DATA;
    end else begin
      din_meta_reg <= i_mgmt_data;
      din_sync_reg <= din_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame fields
  always_comb begin
    if (i_cmd.is_write) begin
      op_field   = MDMST_OP_WRITE;
      ta_field   = MDMST_TA_WRITE;
      data_field = i_cmd.wdata;
    end else begin
      op_field   = MDMST_OP_READ;
      ta_field   = MDMST_TA_READ;
      data_field = MDMST_READ_FILL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer: next values
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next   = bit_reg;
    write_next = write_reg;
    dout_next  = dout_reg;
    oe_next    = oe_reg;
    rdata_next = rdata_reg;
    nores_next = nores_reg;
    case (state_reg)
      MDMST_IDLE: begin
        dout_next = MDMST_IDLE_DATA;
        oe_next   = 1'b1;
        if (i_cmd_valid) begin
          // address zero is sent like any other and reaches every slave
          shift_next = {MDMST_PREAMBLE, MDMST_START, op_field,
                        i_cmd.phy_addr, i_cmd.reg_addr,
                        ta_field, data_field};
          bit_next   = 6'h00;
          write_next = i_cmd.is_write;
          dout_next  = MDMST_PREAMBLE[31];
          oe_next    = 1'b1;
          nores_next = 1'b0;
          rdata_next = MDMST_RDATA_RESET;
          state_next = MDMST_SHIFT;
        end
      end
      MDMST_SHIFT: begin
        // the slave samples on the rise; a new bit goes out on each fall
        if (mdc_rise && !write_reg) begin
          if (bit_reg == MDMST_TA_LAST_BIT) begin
            // the pull-up leaves the line high when nobody answers
            nores_next = din_sync_reg;
          end
          if (bit_reg >= MDMST_DATA_BIT) begin
            rdata_next = {rdata_reg[14:0], din_sync_reg};
          end
        end
        if (mdc_fall) begin
          if (bit_reg == MDMST_LAST_BIT) begin
            dout_next  = MDMST_IDLE_DATA;
            oe_next    = 1'b1;
            state_next = MDMST_DONE;
          end else begin
            bit_next   = bit_reg + 6'h01;
            shift_next = {shift_reg[62:0], 1'b1};
            dout_next  = shift_reg[62];
            // on a read the line is let go for turnaround and data
            oe_next    = write_reg || ((bit_reg + 6'h01) < MDMST_TA_FIRST_BIT);
          end
        end
      end
      MDMST_DONE: begin
        state_next = MDMST_IDLE;
      end
      default: begin
        state_next = MDMST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer: registers
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= MDMST_IDLE;
      shift_reg <= {MDMST_FRAME_BITS{1'b1}};
      bit_reg   <= 6'h00;
      write_reg <= 1'b0;
      dout_reg  <= MDMST_IDLE_DATA;
      oe_reg    <= 1'b1;
      rdata_reg <= MDMST_RDATA_RESET;
      nores_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      write_reg <= write_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      rdata_reg <= rdata_next;
      nores_reg <= nores_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_cmd_ready          = (state_reg == MDMST_IDLE);
  assign o_busy               = (state_reg != MDMST_IDLE);
  assign o_rsp_valid          = (state_reg == MDMST_DONE);
  assign o_rsp.rdata          = rdata_reg;
  assign o_rsp.no_response    = nores_reg;
  assign o_rsp.was_write      = write_reg;
  assign o_mgmt_clock         = mdc;
  assign o_mgmt_data          = dout_reg;
  assign o_mgmt_data_oe       = oe_reg;

endmodule : mdmst_master

/* File: verilog/mdmst_pkg.sv */
/*
  constants and types for the management-serial master that drives a device's
  management clock and data pins from outside.
  assumes a 100 MHz core clock and one shared, pulled-up data wire.
*/
package mdmst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int unsigned MDMST_CORE_CLK_KHZ = 100000;
  localparam int unsigned MDMST_MDC_MAX_KHZ  = 2500;
  // half period is (divide + 1) core cycles: 100 MHz / 40 = 2.5 MHz
  localparam logic [5:0]  MDMST_DIV_DEFAULT  = 6'h13;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout, bit 0 is the first bit on the wire
  localparam int unsigned MDMST_FRAME_BITS   = 64;
  localparam logic [31:0] MDMST_PREAMBLE     = 32'hffffffff;
  localparam logic [1:0]  MDMST_START        = 2'h1;
  localparam logic [1:0]  MDMST_OP_WRITE     = 2'h1;
  localparam logic [1:0]  MDMST_OP_READ      = 2'h2;
  localparam logic [1:0]  MDMST_TA_WRITE     = 2'h2;
  localparam logic [1:0]  MDMST_TA_READ      = 2'h3;
  localparam logic [15:0] MDMST_READ_FILL    = 16'hffff;
  localparam logic [5:0]  MDMST_TA_FIRST_BIT = 6'h2e;
  localparam logic [5:0]  MDMST_TA_LAST_BIT  = 6'h2f;
  localparam logic [5:0]  MDMST_DATA_BIT     = 6'h30;
  localparam logic [5:0]  MDMST_LAST_BIT     = 6'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // values held while idle and after reset
  localparam logic        MDMST_IDLE_DATA    = 1'b1;
  localparam logic        MDMST_IDLE_CLK     = 1'b0;
  localparam logic [15:0] MDMST_RDATA_RESET  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        is_write;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mdmst_cmd_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        no_response;
    logic        was_write;
  } mdmst_rsp_t;

  typedef enum logic [1:0] {
    MDMST_IDLE  = 2'b00,
    MDMST_SHIFT = 2'b01,
    MDMST_DONE  = 2'b10
  } mdmst_state_t;

endpackage : mdmst_pkg
